/* rtl/dma_channel_controller.sv */
// four-channel dma controller with axi4-lite register slave
// assumes one clock; memory port answers with a one-cycle mem_ack
// What this block does
// - timer events and external interrupts may trigger transfers.
// - each channel moves data one way only, set by its direction bit.
// - fixed channel-number priority picks one; others stay pending.
// - interrupt after whole block, or at the half point if chosen.
// - post-increment memory addressing mode.
// - fixed memory address mode.
// - peripheral-indirect mode uses the address the peripheral supplies.
// - byte or word transfers per channel.
// - transfers start by software force or by selected peripheral request.
// - one-shot stops after one block; auto-repeat restarts it.
// - ping-pong alternates between two sram start addresses per block.
// - eight-bit request-select field chooses the request source.
// - code zero selects external interrupt zero, no peripheral address.
// - capture sources codes and buffer addresses from 0x0144 step 8.
// - compare sources codes; compare registers 0x0910 and 0x090E.
// - serial receiver code 0x0B reads address 0x0226.
// - serial transmitter code 0x0C writes address 0x0224.
// - bus-controller receive code 0x22 reads address 0x0440.
// - bus-controller transmit code 0x46 writes address 0x0442.
// - converter-done code 0x0D reads address 0x0300.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_controller #(
	parameter int EVT_W = 128,
	parameter int CNT_W = 16
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 ce,
	input  wire logic [dma_pkg::AW-1:0] s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [dma_pkg::AW-1:0] s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic [EVT_W-1:0]     event_in,
	input  wire logic [15:0]          pia_addr,
	output dma_pkg::mem_req_t         mem_req,
	input  wire logic                 mem_ack,
	input  wire logic [15:0]          mem_rdata,
	output logic [dma_pkg::NCH-1:0]   chan_irq
);
	import dma_pkg::*;

	logic [15:0]      ctrl_reg [NCH];
	logic [7:0]       sel_reg  [NCH];
	logic [15:0]      sta_reg  [NCH];
	logic [15:0]      stb_reg  [NCH];
	logic [15:0]      pad_reg  [NCH];
	logic [CNT_W-1:0] cnt_reg  [NCH];
	logic [NCH-1:0]   pend_reg;
	logic [NCH-1:0]   done_reg;
	logic [NCH-1:0]   half_reg;
	logic [AW-1:0]    aw_addr_reg;
	logic [31:0]      w_data_reg;
	logic [3:0]       w_strb_reg;
	logic             aw_have_reg;
	logic             w_have_reg;
	state_t           state_reg;
	logic [1:0]       cur_reg;
	logic [15:0]      data_reg;
	logic [15:0]      pia_reg;
	logic [EVT_W-1:0] evt_s;
	logic [EVT_W-1:0] evt_d_reg;
	logic [EVT_W-1:0] evt_rise;
	logic [CNT_W-1:0] idx      [NCH];
	logic [NCH-1:0]   pp;
	logic [NCH-1:0]   at_last;
	logic [NCH-1:0]   at_half;
	logic [NCH-1:0]   trig;
	logic [NCH-1:0]   restart;
	logic [NCH-1:0]   step;
	logic             wr_go;
	logic [1:0]       wr_ch;
	logic [2:0]       wr_idx;
	logic             wr_ok;
	logic [1:0]       rd_ch;
	logic [2:0]       rd_idx;
	logic             any_pend;
	logic [1:0]       win;
	logic [15:0]      sram_addr;
	logic [15:0]      cur_ctrl;
	logic             blk_end;

	// request lines come from outside logic: synchronise, then rising edge
	evt_sync #(.W(EVT_W)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.d       (event_in),
		.q       (evt_s)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			evt_d_reg <= '0;
		else if (ce)
			evt_d_reg <= evt_s;
	end

	assign evt_rise = evt_s & ~evt_d_reg;

	// write and read decode
	assign wr_go  = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign wr_ch  = aw_addr_reg[CH_LSB+1:CH_LSB];
	assign wr_idx = aw_addr_reg[CH_LSB-1:REG_LSB];
	assign wr_ok  = !aw_addr_reg[AW-1] && (wr_idx <= REG_STAT);
	assign rd_ch  = s_axi_araddr[CH_LSB+1:CH_LSB];
	assign rd_idx = s_axi_araddr[CH_LSB-1:REG_LSB];

	// per-channel context and trigger terms
	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : gen_ch
			// selected source, only while enabled
			assign trig[g] = ctrl_reg[g][CTRL_EN] && !sel_reg[g][7]
				&& evt_rise[sel_reg[g][6:0]];
			assign restart[g] = wr_go && wr_ok && (wr_ch == 2'(g))
				&& (wr_idx == REG_CTRL) && w_data_reg[CTRL_EN]
				&& !ctrl_reg[g][CTRL_EN];
			assign step[g] = (state_reg == ST_WR) && mem_ack && (cur_reg == 2'(g));
			chan_ctx #(.CW(CNT_W)) u_ctx (
				.aclk    (aclk),
				.aresetn (aresetn),
				.ce      (ce),
				.restart (restart[g]),
				.step    (step[g]),
				.pp_en   (ctrl_reg[g][CTRL_PP]),
				.last    (cnt_reg[g]),
				.idx_reg (idx[g]),
				.pp_reg  (pp[g]),
				.at_last (at_last[g]),
				.at_half (at_half[g])
			);
		end
	endgenerate

	// fixed priority: lowest channel number wins
	always_comb
	begin
		win = 2'h0;
		for (int i = NCH - 1; i >= 0; i--)
			if (pend_reg[i])
				win = 2'(i);
	end

	assign any_pend = |pend_reg;
	assign cur_ctrl = ctrl_reg[cur_reg];
	assign blk_end  = at_last[cur_reg];

	// sram side address of the current transfer
	always_comb
	begin
		sram_addr = pp[win] ? stb_reg[win] : sta_reg[win];
		if (ctrl_reg[win][CTRL_AM+1:CTRL_AM] == AM_INC)
			sram_addr = 16'(sram_addr + (ctrl_reg[win][CTRL_BYTE] ? 16'(idx[win])
				: 16'(idx[win] << 1)));
		else if (ctrl_reg[win][CTRL_AM+1:CTRL_AM] == AM_PIA)
			sram_addr = pia_addr;
	end

	// axi write address and data capture, either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_addr_reg   <= '0;
			w_data_reg    <= '0;
			w_strb_reg    <= '0;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_addr_reg   <= s_axi_awaddr;
				aw_have_reg   <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
				w_have_reg   <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				aw_have_reg   <= 1'b0;
				w_have_reg    <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OK;
		end
		else if (ce)
		begin
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// configuration registers; written only when byte lane 0 is strobed
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				ctrl_reg[i] <= RST16;
				sel_reg[i]  <= RST8;
				sta_reg[i]  <= RST16;
				stb_reg[i]  <= RST16;
				pad_reg[i]  <= RST16;
				cnt_reg[i]  <= '0;
			end
		end
		else if (ce)
		begin
			if (wr_go && wr_ok && w_strb_reg[0])
			begin
				if (wr_idx == REG_CTRL)
					ctrl_reg[wr_ch] <= {8'h00, w_data_reg[7:0]};
				else if (wr_idx == REG_SEL)
				begin
					sel_reg[wr_ch] <= w_data_reg[7:0];
					pad_reg[wr_ch] <= default_pad(w_data_reg[7:0]);
				end
				else if (wr_idx == REG_STA)
					sta_reg[wr_ch] <= w_data_reg[15:0];
				else if (wr_idx == REG_STB)
					stb_reg[wr_ch] <= w_data_reg[15:0];
				else if (wr_idx == REG_PAD)
					pad_reg[wr_ch] <= w_data_reg[15:0];
				else if (wr_idx == REG_CNT)
					cnt_reg[wr_ch] <= w_data_reg[CNT_W-1:0];
			end
			// one-shot disables itself at block end
			if (step[cur_reg] && blk_end && cur_ctrl[CTRL_ONE])
				ctrl_reg[cur_reg][CTRL_EN] <= 1'b0;
		end
	end

	// pending requests; a new request beats the clear of a served one
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pend_reg <= '0;
		else if (ce)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (trig[i] || (wr_go && wr_ok && wr_ch == 2'(i) && wr_idx == REG_CTRL
					&& w_data_reg[CTRL_FORCE] && w_data_reg[CTRL_EN]))
					pend_reg[i] <= 1'b1;
				else if (state_reg == ST_IDLE && any_pend && win == 2'(i))
					pend_reg[i] <= 1'b0;
				else if (!ctrl_reg[i][CTRL_EN])
					pend_reg[i] <= 1'b0;
			end
		end
	end

	// status flags: hardware set wins over write-one-to-clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			done_reg <= '0;
			half_reg <= '0;
			chan_irq <= '0;
		end
		else if (ce)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				chan_irq[i] <= step[i] && (ctrl_reg[i][CTRL_HALF] ? at_half[i]
					: at_last[i]);
				if (step[i] && at_last[i])
					done_reg[i] <= 1'b1;
				else if (wr_go && wr_ok && wr_ch == 2'(i) && wr_idx == REG_STAT
					&& w_data_reg[0])
					done_reg[i] <= 1'b0;
				if (step[i] && at_half[i])
					half_reg[i] <= 1'b1;
				else if (wr_go && wr_ok && wr_ch == 2'(i) && wr_idx == REG_STAT
					&& w_data_reg[1])
					half_reg[i] <= 1'b0;
			end
		end
	end

	// transfer engine: read source, then write destination
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= ST_IDLE;
			cur_reg   <= 2'h0;
			mem_req   <= '0;
			data_reg  <= RST16;
			pia_reg   <= RST16;
		end
		else if (ce)
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (any_pend)
					begin
						cur_reg       <= win;
						pia_reg       <= sram_addr;
						mem_req.valid <= 1'b1;
						mem_req.write <= 1'b0;
						mem_req.wide  <= !ctrl_reg[win][CTRL_BYTE];
						mem_req.addr  <= ctrl_reg[win][CTRL_DIR] ? sram_addr
							: pad_reg[win];
						state_reg     <= ST_RD;
					end
				end
				ST_RD:
				begin
					if (mem_ack)
					begin
						data_reg      <= mem_rdata;
						mem_req.write <= 1'b1;
						mem_req.addr  <= cur_ctrl[CTRL_DIR] ? pad_reg[cur_reg] : pia_reg;
						mem_req.wdata <= cur_ctrl[CTRL_BYTE] ? {8'h00, mem_rdata[7:0]}
							: mem_rdata;
						state_reg     <= ST_WR;
					end
				end
				ST_WR:
				begin
					if (mem_ack)
					begin
						mem_req.valid <= 1'b0;
						mem_req.write <= 1'b0;
						state_reg     <= ST_END;
					end
				end
				ST_END:
					state_reg <= ST_IDLE;
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OK;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= RESP_OK;
				if (s_axi_araddr[AW-1])
				begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_ERR;
				end
				else if (rd_idx == REG_CTRL)
					s_axi_rdata <= {16'h0000, ctrl_reg[rd_ch]};
				else if (rd_idx == REG_SEL)
					s_axi_rdata <= {24'h000000, sel_reg[rd_ch]};
				else if (rd_idx == REG_STA)
					s_axi_rdata <= {16'h0000, sta_reg[rd_ch]};
				else if (rd_idx == REG_STB)
					s_axi_rdata <= {16'h0000, stb_reg[rd_ch]};
				else if (rd_idx == REG_PAD)
					s_axi_rdata <= {16'h0000, pad_reg[rd_ch]};
				else if (rd_idx == REG_CNT)
					s_axi_rdata <= 32'(cnt_reg[rd_ch]);
				else if (rd_idx == REG_STAT)
					s_axi_rdata <= {16'h0000, 16'(idx[rd_ch]) << 4
						| {12'h000, pend_reg[rd_ch], pp[rd_ch], half_reg[rd_ch],
						done_reg[rd_ch]}};
				else
				begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_ERR;
				end
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* inc/dma_pkg.sv */
// package: constants, codes and carrier types of the dma channel controller
// assumes one clock domain; the controller and the bench files import this package
package dma_pkg;
	localparam int NCH = 4;
	localparam int AW  = 8;
	// register map: channel in addr[6:5], register in addr[4:2]
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_SEL  = 3'h1;
	localparam logic [2:0] REG_STA  = 3'h2;
	localparam logic [2:0] REG_STB  = 3'h3;
	localparam logic [2:0] REG_PAD  = 3'h4;
	localparam logic [2:0] REG_CNT  = 3'h5;
	localparam logic [2:0] REG_STAT = 3'h6;
	localparam int CH_LSB  = 5;
	localparam int REG_LSB = 2;
	// ctrl word fields
	localparam int CTRL_EN    = 0;
	localparam int CTRL_DIR   = 1;
	localparam int CTRL_BYTE  = 2;
	localparam int CTRL_ONE   = 3;
	localparam int CTRL_PP    = 4;
	localparam int CTRL_HALF  = 5;
	localparam int CTRL_AM    = 6;
	localparam int CTRL_FORCE = 8;
	localparam logic [15:0] RST16 = 16'h0000;
	localparam logic [7:0]  RST8  = 8'h00;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;
	// addressing modes
	localparam logic [1:0] AM_INC   = 2'h0;
	localparam logic [1:0] AM_FIXED = 2'h1;
	localparam logic [1:0] AM_PIA   = 2'h2;
	// request-select codes
	localparam logic [7:0] SEL_EXT0  = 8'h00;
	localparam logic [7:0] SEL_CAP1  = 8'h01;
	localparam logic [7:0] SEL_CAP2  = 8'h05;
	localparam logic [7:0] SEL_CAP3  = 8'h25;
	localparam logic [7:0] SEL_CAP4  = 8'h26;
	localparam logic [7:0] SEL_CMP1  = 8'h02;
	localparam logic [7:0] SEL_CMP2  = 8'h06;
	localparam logic [7:0] SEL_CMP3  = 8'h19;
	localparam logic [7:0] SEL_CMP4  = 8'h1A;
	localparam logic [7:0] SEL_TMR2  = 8'h07;
	localparam logic [7:0] SEL_TMR3  = 8'h08;
	localparam logic [7:0] SEL_TMR4  = 8'h1B;
	localparam logic [7:0] SEL_TMR5  = 8'h1C;
	localparam logic [7:0] SEL_SRX1  = 8'h0B;
	localparam logic [7:0] SEL_STX1  = 8'h0C;
	localparam logic [7:0] SEL_BCRX  = 8'h22;
	localparam logic [7:0] SEL_BCTX  = 8'h46;
	localparam logic [7:0] SEL_CONV  = 8'h0D;
	// peripheral data addresses
	localparam logic [15:0] PAD_CAP1  = 16'h0144;
	localparam logic [15:0] PAD_CAP_STEP = 16'h0008;
	localparam logic [15:0] PAD_CMP2P = 16'h0910;
	localparam logic [15:0] PAD_CMP2S = 16'h090E;
	localparam logic [15:0] PAD_SRX1  = 16'h0226;
	localparam logic [15:0] PAD_STX1  = 16'h0224;
	localparam logic [15:0] PAD_BCRX  = 16'h0440;
	localparam logic [15:0] PAD_BCTX  = 16'h0442;
	localparam logic [15:0] PAD_CONV  = 16'h0300;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_RD   = 4'b0010,
		ST_WR   = 4'b0100,
		ST_END  = 4'b1000
	} state_t;

	// one access towards sram or a peripheral register
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        wide;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_req_t;

	// default peripheral address loaded when a source is selected
	function automatic logic [15:0] default_pad(input logic [7:0] code);
		case (code)
			SEL_CAP1: default_pad = PAD_CAP1;
			SEL_CAP2: default_pad = 16'(PAD_CAP1 + PAD_CAP_STEP);
			SEL_CAP3: default_pad = 16'(PAD_CAP1 + 2 * PAD_CAP_STEP);
			SEL_CAP4: default_pad = 16'(PAD_CAP1 + 3 * PAD_CAP_STEP);
			SEL_CMP2: default_pad = PAD_CMP2P;
			SEL_SRX1: default_pad = PAD_SRX1;
			SEL_STX1: default_pad = PAD_STX1;
			SEL_BCRX: default_pad = PAD_BCRX;
			SEL_BCTX: default_pad = PAD_BCTX;
			SEL_CONV: default_pad = PAD_CONV;
			default:  default_pad = RST16;
		endcase
	endfunction
endpackage

/* rtl/evt_sync.sv */
// two-stage synchroniser for the request lines
// assumes aclk domain, synchronous active-low reset, clock enable
`timescale 1ns/1ps
`default_nettype none
module evt_sync #(
	parameter int W = 128
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_reg <= '0;
			q        <= '0;
		end
		else if (ce)
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule
`default_nettype wire

/* rtl/chan_ctx.sv */
// per-channel block position and ping-pong buffer select
// assumes aclk domain; step comes once per finished transfer
`timescale 1ns/1ps
`default_nettype none
module chan_ctx #(
	parameter int CW = 16
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          ce,
	input  wire logic          restart,
	input  wire logic          step,
	input  wire logic          pp_en,
	input  wire logic [CW-1:0] last,
	output logic      [CW-1:0] idx_reg,
	output logic               pp_reg,
	output logic               at_last,
	output logic               at_half
);
	logic [CW:0] half_pt;

	// block ends after last+1 transfers; half point at (last+1)/2
	assign half_pt = ({1'b0, last} + (CW+1)'(1)) >> 1;
	assign at_last = (idx_reg == last);
	assign at_half = ({1'b0, idx_reg} + 1'b1) == half_pt;

	// position and buffer select
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			idx_reg <= '0;
			pp_reg  <= 1'b0;
		end
		else if (ce)
		begin
			if (restart)
			begin
				idx_reg <= '0;
				pp_reg  <= 1'b0;
			end
			else if (step && at_last)
			begin
				idx_reg <= '0;
				pp_reg  <= pp_en ? !pp_reg : 1'b0;
			end
			else if (step)
				idx_reg <= CW'(idx_reg + 1'b1);
		end
	end
endmodule
`default_nettype wire

/* bench/dma_monitor.sv */
// checker: memory-port sequencing, interrupt pulses and bus handshakes
// assumes ce drops only while idle; bound to the controller's top module
`timescale 1ns/1ps
`default_nettype none
module dma_monitor
(
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_awready,
	input wire logic                  s_axi_bvalid,
	input wire dma_pkg::mem_req_t     mem_req,
	input wire logic                  mem_ack,
	input wire logic [dma_pkg::NCH-1:0] chan_irq
);
	import dma_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// read half and write half of one transfer
	sequence s_rd_ack;
		mem_req.valid && !mem_req.write && mem_ack;
	endsequence
	sequence s_wr_ack;
		mem_req.valid && mem_req.write && mem_ack;
	endsequence
	a_req_hold: assert property (mem_req.valid && !mem_ack |=> $stable(mem_req))
		else $error("memory request changed before ack");
	a_rd_then_wr: assert property (s_rd_ack |=> mem_req.valid && mem_req.write)
		else $error("read not followed by its write");
	a_wr_then_gap: assert property (s_wr_ack |=> !mem_req.valid [*2])
		else $error("no idle gap after a transfer");
	a_byte_upper: assert property (mem_req.valid && mem_req.write && !mem_req.wide
		|-> mem_req.wdata[15:8] == 8'h00) else $error("byte write upper byte not zero");
	a_irq_onehot: assert property ($onehot0(chan_irq))
		else $error("two channels interrupt at once");
	a_irq_pulse: assert property (chan_irq != '0 |=> chan_irq == '0)
		else $error("interrupt longer than one cycle");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read not answered next cycle");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken while response pending");
endmodule
`default_nettype wire

/* bench/mem_partner.sv */
// partner: sram and peripheral registers behind the memory port
// assumes one clock; slow inserts three wait cycles before each ack
`timescale 1ns/1ps
`default_nettype none
module mem_partner
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              slow,
	input  wire dma_pkg::mem_req_t mem_req,
	output logic                   mem_ack,
	output logic [15:0]            mem_rdata
);
	import dma_pkg::*;
	logic [1:0]  wait_reg;
	logic [15:0] last_reg;
	logic [15:0] pat;
	// read contents follow the address so every word is distinct
	assign pat = {mem_req.addr[7:0] ^ 8'h5A, mem_req.addr[15:8] ^ 8'hC3};
	// outside an ack the data lines carry the inverse of the last value
	assign mem_rdata = (mem_ack && !mem_req.write) ? pat : ~last_reg;
	// count wait states, then ack for one cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !mem_req.valid || mem_ack)
		begin
			mem_ack  <= 1'b0;
			wait_reg <= slow ? 2'h3 : 2'h0;
		end
		else if (wait_reg != 2'h0)
			wait_reg <= wait_reg - 2'h1;
		else
			mem_ack <= 1'b1;
	end
	// remember the last driven data
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			last_reg <= '0;
		else
			last_reg <= mem_rdata;
	end
endmodule
`default_nettype wire

/* bench/test_dma_channel_controller.sv */
// bench: programs channels over the register bus, raises requests, checks results
// assumes mem_partner on the memory port; ce dropped only while idle
`timescale 1ns/1ps
`default_nettype none
module test_dma_channel_controller;
	import dma_pkg::*;
	logic        aclk, aresetn, ce, slow, mem_ack;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, chan_irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [127:0] event_in;
	logic [15:0] pia_addr, mem_rdata, sa, sb;
	mem_req_t    mem_req;
	logic [31:0] wq[$], iq[$], rq[$];
	int          errors = 0;
	int          checks_done = 0;
	// request codes and their peripheral addresses
	logic [7:0]  codes[12] = '{8'h00, 8'h01, 8'h05, 8'h25, 8'h26, 8'h06,
		8'h0B, 8'h0C, 8'h22, 8'h46, 8'h0D, 8'h1C};
	logic [15:0] pads[12] = '{16'h0000, 16'h0144, 16'h014C, 16'h0154, 16'h015C, 16'h0910,
		16'h0226, 16'h0224, 16'h0440, 16'h0442, 16'h0300, 16'h0000};
	// 125 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	dma_channel_controller #(.EVT_W(128), .CNT_W(16)) dut_u (.aclk, .aresetn, .ce,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .event_in, .pia_addr, .mem_req, .mem_ack,
		.mem_rdata, .chan_irq);
	mem_partner mem_u (.aclk, .aresetn, .slow, .mem_req, .mem_ack, .mem_rdata);
	function automatic logic [15:0] pat(input logic [15:0] a);
		return {a[7:0] ^ 8'h5A, a[15:8] ^ 8'hC3};
	endfunction
	function automatic logic [7:0] ra(input int ch, input logic [2:0] r);
		return 8'(ch * 32 + 4 * r);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d, errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic give_up;
		errors++;
		close_out();
	endtask
	// one register access; handshakes judged at the falling edge, acted on at the rising
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		logic aw, w, ar, r;
		r = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		for (n = 0; n < 40 && !r; n++)
		begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			ar = s_axi_arvalid && s_axi_arready;
			r = wr ? s_axi_bvalid : s_axi_rvalid;
			if (r)
				check({30'h0, wr ? s_axi_bresp : s_axi_rresp}, {30'h0, er});
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
			if (ar)
				s_axi_arvalid <= 1'b0;
			if (r)
				{s_axi_bready, s_axi_rready} <= 2'b00;
		end
		if (!r)
			give_up();
	endtask
	task automatic cfg(input int ch, input logic [7:0] sel, input logic [15:0] a,
		input logic [15:0] b, input logic [31:0] cnt, input logic [31:0] ctl);
		bus(1'b1, ra(ch, REG_SEL), {24'h0, sel}, RESP_OK);
		bus(1'b1, ra(ch, REG_STA), {16'h0, a}, RESP_OK);
		bus(1'b1, ra(ch, REG_STB), {16'h0, b}, RESP_OK);
		bus(1'b1, ra(ch, REG_CNT), cnt, RESP_OK);
		bus(1'b1, ra(ch, REG_CTRL), ctl, RESP_OK);
	endtask
	task automatic drain;
		int n;
		for (n = 0; n < 400 && wq.size() + iq.size() > 0; n++)
			@(posedge aclk);
		if (n == 400)
			give_up();
		repeat (8) @(posedge aclk);
	endtask
	// request line pulse, then wait for the noted results
	task automatic fire(input int code);
		@(posedge aclk);
		event_in[code] <= 1'b1;
		repeat (4) @(posedge aclk);
		event_in[code] <= 1'b0;
		drain();
	endtask
	// compare each result on the outputs against the oldest note
	always @(negedge aclk)
	begin
		if (s_axi_rvalid && s_axi_rready)
			check(s_axi_rdata, rq.pop_front());
		if (mem_req.valid && mem_req.write && mem_ack)
			check({mem_req.addr, mem_req.wdata}, wq.pop_front());
		if (chan_irq != 4'h0)
			check({28'h0, chan_irq}, iq.pop_front());
	end
	// main sequence
	initial
	begin
		{aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, event_in, pia_addr} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		ce = 1'b1;
		s_axi_wstrb = 4'($urandom(32'h5f69)) | 4'h1;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		// reset value, unmapped read and write
		rq.push_back(32'h0);
		bus(1'b0, ra(0, REG_CTRL), 32'h0, RESP_OK);
		rq.push_back(32'h0);
		bus(1'b0, 8'h1C, 32'h0, RESP_ERR);
		bus(1'b1, 8'h80, 32'h1, RESP_ERR);
		// twelve request codes each load their peripheral address
		foreach (codes[i])
		begin
			bus(1'b1, ra(0, REG_SEL), {24'h0, codes[i]}, RESP_OK);
			rq.push_back({16'h0, pads[i]});
			bus(1'b0, ra(0, REG_PAD), 32'h0, RESP_OK);
		end
		// ch0: peripheral to sram, word, incrementing, one-shot, half irq, two per block
		sa = 16'($urandom) & 16'hFFFE;
		cfg(0, SEL_SRX1, sa, sa, 32'h1, 32'h29);
		wq.push_back({sa, pat(PAD_SRX1)});
		iq.push_back(32'h1);
		fire(SEL_SRX1);
		wq.push_back({16'(sa + 16'h2), pat(PAD_SRX1)});
		fire(SEL_SRX1);
		fire(SEL_SRX1);
		rq.push_back(32'h28);
		bus(1'b0, ra(0, REG_CTRL), 32'h0, RESP_OK);
		rq.push_back(32'h3);
		bus(1'b0, ra(0, REG_STAT), 32'h0, RESP_OK);
		// ch1: sram to peripheral, byte, fixed, ping-pong, forced, auto-repeat
		sa = 16'($urandom);
		sb = 16'($urandom);
		cfg(1, SEL_STX1, sa, sb, 32'h0, 32'h57);
		for (int k = 0; k < 2; k++)
		begin
			wq.push_back({PAD_STX1, 8'h00, 8'(pat(k ? sb : sa))});
			iq.push_back(32'h2);
			bus(1'b1, ra(1, REG_CTRL), 32'h157, RESP_OK);
			drain();
		end
		// a write without the low byte lane is answered but changes nothing
		s_axi_wstrb <= s_axi_wstrb & 4'hE;
		bus(1'b1, ra(1, REG_CTRL), 32'h0, RESP_OK);
		s_axi_wstrb <= s_axi_wstrb | 4'h1;
		rq.push_back(32'h57);
		bus(1'b0, ra(1, REG_CTRL), 32'h0, RESP_OK);
		// ch2 peripheral-indirect and ch3 share one timer request; slow memory
		slow <= !slow;
		pia_addr <= 16'($urandom);
		sa = 16'($urandom);
		cfg(3, SEL_TMR5, sa, sa, 32'h0, 32'h1);
		cfg(2, SEL_TMR5, sa, sa, 32'h0, 32'h81);
		wq.push_back({pia_addr, pat(16'h0)});
		wq.push_back({sa, pat(16'h0)});
		iq.push_back(32'h4);
		iq.push_back(32'h8);
		fire(SEL_TMR5);
		// a request pulse inside a clock-enable gap is never seen
		ce <= !ce;
		fire(SEL_TMR5);
		ce <= !ce;
		repeat (8) @(posedge aclk);
		// reset in mid-run clears the configuration
		aresetn <= !aresetn;
		repeat (2) @(posedge aclk);
		aresetn <= !aresetn;
		rq.push_back(32'h0);
		bus(1'b0, ra(1, REG_CTRL), 32'h0, RESP_OK);
		check(32'(wq.size() + iq.size() + rq.size()), 32'h0);
		close_out();
	end
endmodule
bind dma_channel_controller dma_monitor mon_u (.aclk, .aresetn, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_awready, .s_axi_bvalid, .mem_req, .mem_ack,
	.chan_irq);
`default_nettype wire
